/* logic/aslif_pkg.sv */
package aslif_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CHAR_W = 8;

  // register offsets from the device base address
  localparam logic [17:0] OFS_RX_CS = 18'h00000;
  localparam logic [17:0] OFS_RX_HOLD = 18'h00002;
  localparam logic [17:0] OFS_TX_CS = 18'h00004;
  localparam logic [17:0] OFS_TX_HOLD = 18'h00006;
  localparam logic [17:0] BASE_ADDR_DEFAULT = 18'h3ff70;

  // field positions
  localparam int CS_DONE_BIT = 7;
  localparam int CS_IE_BIT = 6;
  localparam int ST_ERROR_BIT = 15;
  localparam int ST_OVERRUN_BIT = 14;
  localparam int ST_FRAMING_BIT = 13;
  localparam int ST_PARITY_BIT = 12;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int MIN_BPS = 40;
  localparam int MAX_BPS = 10_000;
  localparam int DIV_W = 16;
  localparam logic [15:0] DIV_AT_MAX_BPS = 16'(CLK_HZ / (OVERSAMPLE * MAX_BPS));
  localparam logic [15:0] DIV_AT_MIN_BPS = 16'(CLK_HZ / (OVERSAMPLE * MIN_BPS));
  localparam logic [4:0] TICK_MID = 5'h07;
  localparam logic [4:0] TICK_LAST = 5'h0f;
  localparam logic [4:0] STOP_LAST_ONE = 5'h0f;
  localparam logic [4:0] STOP_LAST_HALF = 5'h17;
  localparam logic [4:0] STOP_LAST_TWO = 5'h1f;
  localparam logic [2:0] FIRST_LAST_IDX = 3'h4;

  localparam logic [2:0] REQ_LEVEL_FOUR = 3'h4;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    LEN_FIVE = 2'b00, LEN_SIX = 2'b01, LEN_SEVEN = 2'b10, LEN_EIGHT = 2'b11
  } aslif_len_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10, PAR_NONE_ALT = 2'b11
  } aslif_parity_t;

  typedef enum logic [1:0] {
    STOP_ONE = 2'b00, STOP_HALF = 2'b01, STOP_TWO = 2'b10, STOP_TWO_ALT = 2'b11
  } aslif_stop_t;

  typedef struct packed {
    aslif_len_t char_len;
    aslif_parity_t parity;
    aslif_stop_t stop;
  } aslif_straps_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [17:0] addr;
    logic [15:0] wdata;
  } aslif_bus_req_t;

  typedef enum logic [2:0] {
    LINE_IDLE = 3'b000, LINE_START = 3'b001, LINE_DATA = 3'b010,
    LINE_PARITY = 3'b011, LINE_STOP = 3'b100
  } aslif_line_t;

endpackage : aslif_pkg

/* logic/aslif_top.sv */
// Functional notes
// [RULE1] receiver assembles 5 to 8 data bits, length set by shared strap
// [RULE2] receive line sampled on a tick at sixteen times receive bit rate
// [RULE3] character moves to receive holding at first stop bit midpoint
// [RULE4] that transfer sets receive-done, bit 7 of receive control/status
// [RULE5] receive-done with receive interrupt enable bit 6 raises receive request
// [RULE6] request level comes from a jumper, level four by default
// [RULE7] character right-aligned in bits 7..0, no start, stop or parity
// [RULE8] unused upper data bits of short characters read as zero
// [RULE9] receive holding bits 8..11 read zero, 12..15 hold character status
// [RULE10] transmitter uses the receiver's character length and stop length
// [RULE11] stop length strap: one, one and a half, or two bit times
// [RULE12] parity generated on transmit, checked on receive: even, odd, none
// [RULE13] transmit-ready bit 7 set whenever holding can accept, even mid-send
// [RULE14] host writes low eight bits of transmit holding only while ready
// [RULE15] two back-to-back characters accepted when idle, none lost
// [RULE16] receive and transmit rates set separately, 40 to 10000 bits/s
// [RULE17] four registers, each decoded at its own 18-bit address
// [RULE18] least significant data bit goes first both ways
// [RULE19] one is mark (high) on transmit; received mark stored as one
// [RULE20] one start bit before data, then the selected stop units
// [RULE21] independent interrupt channels; receive presented first when both request
// [RULE22] reading receive holding clears receive-done
// [RULE23] line idles at mark; start bit begins on next bit-time boundary
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module aslif_tick (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [15:0] divisor, // clocks per tick
  output logic tick // one-cycle tick pulse
);
  logic [15:0] count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count + 16'h0001 >= divisor) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : aslif_tick

////////////////////////////////////////////////////////////////////////////////
module aslif_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // drain request
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  logic push;
  logic pop;

  assign in_ready = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : aslif_fifo

////////////////////////////////////////////////////////////////////////////////
module aslif_top #(
  parameter logic [17:0] BASE_ADDR = aslif_pkg::BASE_ADDR_DEFAULT,
  parameter logic [2:0] REQ_LEVEL = aslif_pkg::REQ_LEVEL_FOUR
) (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic reset_n, // bus reset, active low
  input wire aslif_pkg::aslif_straps_t straps, // character format straps
  input wire logic [15:0] rx_rate_div, // clocks per receive 16x tick
  input wire logic [15:0] tx_rate_div, // clocks per transmit 16x tick
  input wire aslif_pkg::aslif_bus_req_t bus_req, // host register access
  output logic [15:0] bus_rdata, // read data, one cycle later
  output logic bus_ack, // access answered, pulse
  input wire logic serial_in, // received data lead
  output logic serial_out, // transmitted data lead
  output logic rx_irq, // receive request
  output logic tx_irq, // transmit request
  output logic irq_request, // any request to the bus
  output logic irq_is_receive, // request presented is the receiver's
  output logic [2:0] irq_level // jumpered request level
);
  import aslif_pkg::*;

  logic rx_tick;
  logic tx_tick;
  logic hit_rx_cs;
  logic hit_rx_hold;
  logic hit_tx_cs;
  logic hit_tx_hold;
  logic [2:0] last_idx;
  logic [4:0] stop_last;
  logic par_on;

  // [RULE17] full address decode
  assign hit_rx_cs = (bus_req.addr == BASE_ADDR + OFS_RX_CS);
  assign hit_rx_hold = (bus_req.addr == BASE_ADDR + OFS_RX_HOLD);
  assign hit_tx_cs = (bus_req.addr == BASE_ADDR + OFS_TX_CS);
  assign hit_tx_hold = (bus_req.addr == BASE_ADDR + OFS_TX_HOLD);

  // [RULE1] length from strap
  assign last_idx = FIRST_LAST_IDX + 3'(straps.char_len);
  assign par_on = (straps.parity == PAR_EVEN) || (straps.parity == PAR_ODD);

  // [RULE11] stop length in ticks
  always_comb begin
    unique case (straps.stop)
      STOP_ONE: stop_last = STOP_LAST_ONE;
      STOP_HALF: stop_last = STOP_LAST_HALF;
      STOP_TWO, STOP_TWO_ALT: stop_last = STOP_LAST_TWO;
    endcase
  end

  // [RULE16] separate rate dividers
  aslif_tick u_rx_tick (
    .clk(ref_clk),
    .reset_n(reset_n),
    .divisor(rx_rate_div),
    .tick(rx_tick)
  );

  aslif_tick u_tx_tick (
    .clk(ref_clk),
    .reset_n(reset_n),
    .divisor(tx_rate_div),
    .tick(tx_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // receiver
  aslif_line_t rx_state;
  logic [3:0] rx_cnt;
  logic [2:0] rx_idx;
  logic [7:0] rx_shift;
  logic rx_par_bad;
  logic rx_xfer;
  logic [7:0] rx_hold;
  logic rx_done;
  logic rx_ie;
  logic st_overrun;
  logic st_framing;
  logic st_parity;
  logic rx_hold_read;

  assign rx_hold_read = bus_req.read && hit_rx_hold;

  // [RULE2] 16x sampling
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= LINE_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_par_bad <= 1'b0;
      rx_xfer <= 1'b0;
    end else begin
      rx_xfer <= 1'b0;
      if (rx_tick) begin
        rx_cnt <= rx_cnt + 4'h1;
        unique case (rx_state)
          LINE_IDLE: begin
            rx_cnt <= 4'h0;
            if (!serial_in) begin
              rx_state <= LINE_START;
            end
          end
          LINE_START: begin
            // [RULE20] confirm start at midpoint
            if (rx_cnt == TICK_MID[3:0]) begin
              rx_cnt <= 4'h0;
              rx_idx <= 3'h0;
              rx_shift <= 8'h00;
              rx_state <= serial_in ? LINE_IDLE : LINE_DATA;
            end
          end
          LINE_DATA: begin
            if (rx_cnt == TICK_LAST[3:0]) begin
              // [RULE18] lsb first, [RULE19] mark is one, [RULE8] upper stay zero
              rx_shift[rx_idx] <= serial_in;
              rx_idx <= rx_idx + 3'h1;
              if (rx_idx == last_idx) begin
                rx_state <= par_on ? LINE_PARITY : LINE_STOP;
              end
            end
          end
          LINE_PARITY: begin
            if (rx_cnt == TICK_LAST[3:0]) begin
              // [RULE12] parity check
              rx_par_bad <= (^rx_shift ^ serial_in) != (straps.parity == PAR_ODD);
              rx_state <= LINE_STOP;
            end
          end
          LINE_STOP: begin
            // [RULE3] transfer at first stop midpoint
            if (rx_cnt == TICK_LAST[3:0]) begin
              rx_xfer <= 1'b1;
              rx_state <= LINE_IDLE;
            end
          end
          default: rx_state <= LINE_IDLE;
        endcase
      end
    end
  end

  // [RULE7] character held without framing bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_hold <= 8'h00;
      st_overrun <= 1'b0;
      st_framing <= 1'b0;
      st_parity <= 1'b0;
    end else if (rx_xfer) begin
      rx_hold <= rx_shift;
      st_overrun <= rx_done && !rx_hold_read;
      st_framing <= !serial_in;
      st_parity <= par_on && rx_par_bad;
    end
  end

  // [RULE4] done set on transfer; [RULE22] read clears, set wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_done <= 1'b0;
    end else if (rx_xfer) begin
      rx_done <= 1'b1;
    end else if (rx_hold_read) begin
      rx_done <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmitter
  aslif_line_t tx_state;
  logic [4:0] tx_cnt;
  logic [2:0] tx_idx;
  logic [7:0] tx_shift;
  logic tx_ie;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic tx_pop;
  logic tx_bit_end;
  logic tx_stop_end;

  assign tx_bit_end = tx_tick && (tx_cnt[3:0] == TICK_LAST[3:0]);
  assign tx_stop_end = tx_tick && (tx_state == LINE_STOP) && (tx_cnt == stop_last);
  // [RULE23] load only on a bit-time boundary; end of stop is one too
  assign tx_pop = ((tx_state == LINE_IDLE) && tx_bit_end) || tx_stop_end;

  // [RULE15] buffered holding stage, [RULE14] full writes are dropped
  aslif_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(bus_req.write && hit_tx_hold),
    .in_ready(fifo_in_ready),
    .in_data(bus_req.wdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(tx_pop),
    .out_data(fifo_out_data)
  );

  // [RULE10] shared format with receiver
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= LINE_IDLE;
      tx_cnt <= 5'h00;
      tx_idx <= 3'h0;
      tx_shift <= 8'h00;
    end else if (tx_tick) begin
      tx_cnt <= tx_cnt + 5'h01;
      unique case (tx_state)
        LINE_IDLE: begin
          if (tx_bit_end) begin
            tx_cnt <= 5'h00;
            if (fifo_out_valid) begin
              tx_shift <= fifo_out_data;
              tx_state <= LINE_START;
            end
          end
        end
        LINE_START: begin
          if (tx_bit_end) begin
            tx_cnt <= 5'h00;
            tx_idx <= 3'h0;
            tx_state <= LINE_DATA;
          end
        end
        LINE_DATA: begin
          if (tx_bit_end) begin
            tx_cnt <= 5'h00;
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == last_idx) begin
              tx_state <= par_on ? LINE_PARITY : LINE_STOP;
            end
          end
        end
        LINE_PARITY: begin
          if (tx_bit_end) begin
            tx_cnt <= 5'h00;
            tx_state <= LINE_STOP;
          end
        end
        LINE_STOP: begin
          // [RULE11] stop held for selected length
          if (tx_cnt == stop_last) begin
            tx_cnt <= 5'h00;
            // [RULE15] queued character follows with no idle bit
            if (fifo_out_valid) begin
              tx_shift <= fifo_out_data;
              tx_state <= LINE_START;
            end else begin
              tx_state <= LINE_IDLE;
            end
          end
        end
        default: tx_state <= LINE_IDLE;
      endcase
    end
  end

  logic [7:0] tx_masked;
  logic next_serial_out;

  assign tx_masked = tx_shift & (8'hff >> (3'h7 - last_idx));

  always_comb begin
    unique case (tx_state)
      // [RULE20] one start bit
      LINE_START: next_serial_out = 1'b0;
      // [RULE18] lsb first, [RULE19] one drives mark
      LINE_DATA: next_serial_out = tx_shift[tx_idx];
      // [RULE12] parity generation
      LINE_PARITY: next_serial_out = ^tx_masked ^ (straps.parity == PAR_ODD);
      // [RULE23] idle and stop at mark
      default: next_serial_out = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= next_serial_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register access
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_ie <= 1'b0;
      tx_ie <= 1'b0;
    end else if (bus_req.write) begin
      if (hit_rx_cs) begin
        rx_ie <= bus_req.wdata[CS_IE_BIT];
      end
      if (hit_tx_cs) begin
        tx_ie <= bus_req.wdata[CS_IE_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 16'h0000;
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (bus_req.read || bus_req.write) &&
                 (hit_rx_cs || hit_rx_hold || hit_tx_cs || hit_tx_hold);
      bus_rdata <= 16'h0000;
      if (bus_req.read) begin
        if (hit_rx_cs) begin
          bus_rdata[CS_DONE_BIT] <= rx_done;
          bus_rdata[CS_IE_BIT] <= rx_ie;
        end
        // [RULE9] status in 12..15, zero in 8..11
        if (hit_rx_hold) begin
          bus_rdata[7:0] <= rx_hold;
          bus_rdata[ST_ERROR_BIT] <= st_overrun || st_framing || st_parity;
          bus_rdata[ST_OVERRUN_BIT] <= st_overrun;
          bus_rdata[ST_FRAMING_BIT] <= st_framing;
          bus_rdata[ST_PARITY_BIT] <= st_parity;
        end
        // [RULE13] ready follows holding room
        if (hit_tx_cs) begin
          bus_rdata[CS_DONE_BIT] <= fifo_in_ready;
          bus_rdata[CS_IE_BIT] <= tx_ie;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt requests
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
      irq_request <= 1'b0;
      irq_is_receive <= 1'b0;
      irq_level <= 3'h0;
    end else begin
      // [RULE5] receive request
      rx_irq <= rx_done && rx_ie;
      tx_irq <= fifo_in_ready && tx_ie;
      // [RULE21] receive presented first
      irq_request <= (rx_done && rx_ie) || (fifo_in_ready && tx_ie);
      irq_is_receive <= rx_done && rx_ie;
      // [RULE6] jumpered level
      irq_level <= REQ_LEVEL;
    end
  end

endmodule : aslif_top

/* sim/aslif_sva.sv */
`timescale 1ns/1ps

module aslif_sva #(
  parameter logic [17:0] BASE_ADDR = aslif_pkg::BASE_ADDR_DEFAULT,
  parameter logic [2:0] REQ_LEVEL = aslif_pkg::REQ_LEVEL_FOUR
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // reset, active low
  input wire aslif_pkg::aslif_straps_t straps, // format straps
  input wire logic [15:0] rx_rate_div, // receive divisor
  input wire logic [15:0] tx_rate_div, // transmit divisor
  input wire aslif_pkg::aslif_bus_req_t bus_req, // host access
  input wire logic [15:0] bus_rdata, // read data
  input wire logic bus_ack, // access answered
  input wire logic serial_in, // receive lead
  input wire logic serial_out, // transmit lead
  input wire logic rx_irq, // receive request
  input wire logic tx_irq, // transmit request
  input wire logic irq_request, // any request
  input wire logic irq_is_receive, // receive presented
  input wire logic [2:0] irq_level // request level
);
  import aslif_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  logic [17:0] ofs;
  logic req, mapped, rd_rxcs, rd_rxh;
  logic [31:0] low_cnt;
  logic [31:0] bit_clks;

  assign ofs = bus_req.addr - BASE_ADDR;
  assign req = bus_req.read | bus_req.write;
  assign mapped = ofs inside {OFS_RX_CS, OFS_RX_HOLD, OFS_TX_CS, OFS_TX_HOLD};
  assign rd_rxcs = bus_req.read && (ofs == OFS_RX_CS);
  assign rd_rxh = bus_req.read && (ofs == OFS_RX_HOLD);
  assign bit_clks = {12'h0, tx_rate_div, 4'h0};

  // length of the current low run on the transmit lead
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 32'h0;
    end else if (serial_out) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_MAPPED: assert property (req && mapped |=> bus_ack)
    else $error("mapped access not answered");
  AST_ACK_UNMAPPED: assert property (req && !mapped |=> !bus_ack)
    else $error("unmapped access answered");
  AST_RXH_ZERO: assert property (rd_rxh |=> bus_rdata[11:8] == 4'h0)
    else $error("receive holding bits 11..8 not zero");
  AST_DONE_BIT: assert property (rd_rxcs && rx_irq && !$past(rd_rxh) && !$past(rd_rxh, 2)
    |=> bus_rdata[CS_DONE_BIT]) else $error("done bit not shown with receive request");
  AST_RX_CLEAR: assert property (rd_rxh && rx_irq |=> ##1 !rx_irq)
    else $error("receive request kept after holding read");
  AST_PRIORITY: assert property (rx_irq |-> irq_is_receive && irq_request)
    else $error("receive request not presented first");
  AST_ANY_REQ: assert property (irq_request == (rx_irq || tx_irq))
    else $error("request summary wrong");
  AST_LEVEL: assert property ($past(reset_n) |-> irq_level == REQ_LEVEL)
    else $error("request level wrong");
  AST_TX_BIT: assert property ($rose(serial_out) |-> (low_cnt % bit_clks) == 32'h0)
    else $error("low run not whole bit times");
  AST_RDATA_QUIET: assert property (!bus_ack |-> bus_rdata == 16'h0)
    else $error("read data without answer");

  COV_RX_DONE: cover property ($rose(rx_irq));
  COV_UNMAPPED: cover property (req && !mapped);
  COV_TX_FULL: cover property ($fell(tx_irq));
endmodule : aslif_sva

bind aslif_top aslif_sva #(.BASE_ADDR(BASE_ADDR), .REQ_LEVEL(REQ_LEVEL)) aslif_sva_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .straps(straps), .rx_rate_div(rx_rate_div),
  .tx_rate_div(tx_rate_div), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
  .serial_in(serial_in), .serial_out(serial_out), .rx_irq(rx_irq), .tx_irq(tx_irq),
  .irq_request(irq_request), .irq_is_receive(irq_is_receive), .irq_level(irq_level));

/* sim/aslif_term.sv */
`timescale 1ns/1ps

module aslif_term #(
  parameter int RX_DIV = 2,
  parameter int TX_DIV = 3
) (
  input wire logic ref_clk, // system clock
  input wire aslif_pkg::aslif_straps_t straps, // frame format
  input wire logic line_in, // device transmit lead
  output logic line_out // device receive lead
);
  import aslif_pkg::*;

  logic [9:0] got_q[$];
  int start_q[$];
  int cyc = 0;
  int ri;
  logic [7:0] rd;
  logic rpb;

  always @(posedge ref_clk) cyc <= cyc + 1;

  function automatic logic has_par();
    return straps.parity == PAR_EVEN || straps.parity == PAR_ODD;
  endfunction : has_par

  function automatic logic par_of(input logic [7:0] d);
    logic [7:0] mk;
    mk = 8'hff >> (3 - int'(straps.char_len));
    return (^(d & mk)) ^ (straps.parity == PAR_ODD);
  endfunction : par_of

  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : gap

  ////////////////////////////////////////////////////////////////////////////////
  initial line_out = 1'b1;

  task automatic send(input logic [7:0] d, input logic bad_par);
    line_out = 1'b0;
    gap(16 * RX_DIV);
    for (int i = 0; i < 5 + int'(straps.char_len); i++) begin
      line_out = d[i];
      gap(16 * RX_DIV);
    end
    if (has_par()) begin
      line_out = par_of(d) ^ bad_par;
      gap(16 * RX_DIV);
    end
    line_out = 1'b1;
    gap(48 * RX_DIV);
  endtask : send

  ////////////////////////////////////////////////////////////////////////////////
  // decode device frames: {parity bad, stop bad, data}
  initial begin
    forever begin
      @(posedge ref_clk);
      #1;
      if (line_in === 1'b0) begin
        start_q.push_back(cyc);
        rd = 8'h0;
        gap(8 * TX_DIV);
        for (ri = 0; ri < 5 + int'(straps.char_len); ri++) begin
          gap(16 * TX_DIV);
          rd[ri] = line_in;
        end
        rpb = 1'b0;
        if (has_par()) begin
          gap(16 * TX_DIV);
          rpb = line_in !== par_of(rd);
        end
        gap(16 * TX_DIV);
        got_q.push_back({rpb, line_in !== 1'b1, rd});
      end
    end
  end
endmodule : aslif_term

/* sim/aslif_top_tb.sv */
`timescale 1ns/1ps

module aslif_top_tb;
  import aslif_pkg::*;

  localparam int RXD = 2;
  localparam int TXD = 3;
  localparam logic [17:0] B = BASE_ADDR_DEFAULT;

  logic ref_clk, reset_n, bus_ack, serial_in, serial_out;
  logic rx_irq, tx_irq, irq_request, irq_is_receive;
  logic [15:0] bus_rdata, v;
  logic [2:0] irq_level;
  logic [9:0] g0, g1;
  logic [7:0] c, m;
  aslif_straps_t straps;
  aslif_bus_req_t bus_req;
  int num_errors = 0;
  int num_checks = 0;
  int n, s0, s1, bt, fr, st, seen;

  aslif_top aslif_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .straps(straps),
    .rx_rate_div(16'h2), .tx_rate_div(16'h3), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .serial_in(serial_in), .serial_out(serial_out), .rx_irq(rx_irq),
    .tx_irq(tx_irq), .irq_request(irq_request), .irq_is_receive(irq_is_receive),
    .irq_level(irq_level));

  aslif_term #(.RX_DIV(RXD), .TX_DIV(TXD)) aslif_term_i (.ref_clk(ref_clk), .straps(straps),
    .line_in(serial_out), .line_out(serial_in));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one register access; answer sampled 1 ns after the taking edge
  task automatic acc(input logic wr, input logic [17:0] a, input logic [15:0] wd,
                     input logic ea);
    bus_req = '{read: !wr, write: wr, addr: a, wdata: wd};
    @(posedge ref_clk);
    #1;
    bus_req.read = 1'b0;
    bus_req.write = 1'b0;
    v = bus_rdata;
    chk({15'h0, bus_ack}, {15'h0, ea}, "answer");
    @(posedge ref_clk);
    #1;
  endtask : acc

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wait_rx();
    for (n = 0; n < 3000 && rx_irq !== 1'b1; n++) tick(1);
    if (n == 3000) begin
      num_errors++;
      $display("[ERR] %0t no receive request", $time);
      conclude();
    end
  endtask : wait_rx

  task automatic wait_got(input int k);
    for (n = 0; n < 20000 && aslif_term_i.got_q.size() < k; n++) tick(1);
    if (n == 20000) begin
      num_errors++;
      $display("[ERR] %0t transmit frames missing", $time);
      conclude();
    end
  endtask : wait_got

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    straps = '0;
    bus_req = '0;
    tick(3);
    reset_n = 1'b1;
    tick(1);
    acc(0, B + OFS_RX_CS, 16'h0, 1);
    chk(v, 16'h0000, "rx status reset");
    acc(0, B + OFS_TX_CS, 16'h0, 1);
    chk(v, 16'h0080, "tx ready at reset");
    acc(0, B + 18'h8, 16'h0, 0);
    chk(v, 16'h0000, "unmapped read");
    acc(1, B + OFS_RX_HOLD, 16'h00ff, 1);
    acc(0, B + OFS_RX_HOLD, 16'h0, 1);
    chk(v, 16'h0000, "rx holding write ignored");
    acc(1, B + OFS_RX_CS, 16'hffff, 1);
    acc(0, B + OFS_RX_CS, 16'h0, 1);
    chk(v, 16'h0040, "rx enable only");
    acc(1, B + OFS_TX_CS, 16'hffff, 1);
    acc(0, B + OFS_TX_CS, 16'h0, 1);
    chk(v, 16'h00c0, "tx ready and enable");
    tick(1);
    chk({13'h0, tx_irq, irq_request, irq_is_receive}, 16'h6, "tx request");
    chk({13'h0, irq_level}, {13'h0, REQ_LEVEL_FOUR}, "level");
    for (int f = 0; f < 12; f++) begin
      tick(200);
      st = (f + f / 4) % 4;
      straps = '{aslif_len_t'(2'(f % 4)), aslif_parity_t'(2'(f / 4)), aslif_stop_t'(2'(st))};
      m = 8'hff >> (3 - f % 4);
      c = 8'hb6 + 8'(f * 7);
      aslif_term_i.send(c, 1'b0);
      wait_rx();
      chk({14'h0, irq_is_receive, irq_request}, 16'h3, "rx first");
      acc(0, B + OFS_RX_CS, 16'h0, 1);
      chk(v, 16'h00c0, "rx done and enable");
      acc(0, B + OFS_RX_HOLD, 16'h0, 1);
      chk(v, {8'h0, c & m}, "rx char");
      tick(1);
      chk({15'h0, rx_irq}, 16'h0, "done cleared");
      acc(1, B + OFS_TX_HOLD, {8'h0, c}, 1);
      acc(1, B + OFS_TX_HOLD, {8'h0, ~c}, 1);
      wait_got(2);
      g0 = aslif_term_i.got_q.pop_front();
      g1 = aslif_term_i.got_q.pop_front();
      s0 = aslif_term_i.start_q.pop_front();
      s1 = aslif_term_i.start_q.pop_front();
      chk({6'h0, g0}, {8'h0, c & m}, "tx char one");
      chk({6'h0, g1}, {8'h0, ~c & m}, "tx char two");
      bt = 16 * TXD;
      fr = bt * (6 + f % 4 + (f / 4 != 0 ? 1 : 0)) + (st == 0 ? bt : (st == 1 ? bt * 3 / 2 : 2 * bt));
      if (st == 1) begin
        chk(16'(s1 - s0 >= fr && s1 - s0 <= fr + bt), 16'h1, "frame half stop");
      end else begin
        chk(16'(s1 - s0), 16'(fr), "frame length");
      end
    end
    tick(200);
    straps = '{LEN_EIGHT, PAR_EVEN, STOP_TWO};
    aslif_term_i.send(8'h5a, 1'b1);
    wait_rx();
    acc(0, B + OFS_RX_HOLD, 16'h0, 1);
    chk(v, 16'h905a, "parity error");
    aslif_term_i.send(8'h33, 1'b0);
    aslif_term_i.send(8'h44, 1'b0);
    acc(0, B + OFS_RX_HOLD, 16'h0, 1);
    chk({12'h0, v[15:12]}, 16'hc, "overrun");
    seen = 0;
    // back-to-back writes past the queue depth
    for (int i = 0; i < 22; i++) begin
      bus_req = '{1'b0, i < 20, B + OFS_TX_HOLD, 16'(i)};
      tick(1);
      if (tx_irq === 1'b0) seen = 1;
    end
    chk(16'(seen), 16'h1, "queue full");
    wait_got(16);
    tick(1500);
    n = aslif_term_i.got_q.size();
    chk(16'(n == 16 || n == 17), 16'h1, "drain count");
    for (int i = 0; i < n; i++) begin
      chk(16'(aslif_term_i.got_q[i]), 16'(i), "drain order");
    end
    acc(0, B + OFS_TX_CS, 16'h0, 1);
    chk(v, 16'h00c0, "empty ready");
    conclude();
  end
endmodule : aslif_top_tb
